// ==== core/sps_pkg.sv ====
/*
 * Constants for the status pin selector and the feedback prescaler:
 * register offsets, field positions, reset values, selection codes and
 * prescaler codes.
 * Assumes an 8-bit register port with 10-bit addresses.
 */
package sps_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int SEL_W = 6;
   localparam int PRE_W = 3;
   localparam int CNT_W = 6;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_PLL_CTRL = 10'h016;
   localparam logic [ADDR_W-1:0] ADDR_STATUS_PIN_SELECT = 10'h017;
   localparam logic [ADDR_W-1:0] ADDR_GATE_CTRL = 10'h01D;

   // field positions
   localparam int SEL_LSB = 2;
   localparam int SEL_MSB = 7;
   localparam int PRE_LSB = 0;
   localparam int PRE_MSB = 2;
   localparam int LOCK_BIT = 7;

   // reset values
   localparam logic [DATA_W-1:0] RST_PLL_CTRL = 8'h06;
   localparam logic [DATA_W-1:0] RST_STATUS_PIN_SELECT = 8'h00;
   localparam logic [DATA_W-1:0] RST_GATE_CTRL = 8'h00;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

   // prescaler codes
   localparam logic [PRE_W-1:0] PRE_FD_1 = 3'h0;
   localparam logic [PRE_W-1:0] PRE_FD_2 = 3'h1;
   localparam logic [PRE_W-1:0] PRE_DM_2 = 3'h2;
   localparam logic [PRE_W-1:0] PRE_DM_4 = 3'h3;
   localparam logic [PRE_W-1:0] PRE_DM_8 = 3'h4;
   localparam logic [PRE_W-1:0] PRE_DM_16 = 3'h5;
   localparam logic [PRE_W-1:0] PRE_DM_32 = 3'h6;
   localparam logic [PRE_W-1:0] PRE_FD_3 = 3'h7;

   // status pin selection codes
   localparam logic [SEL_W-1:0] SEL_GROUND = 6'h00;
   localparam logic [SEL_W-1:0] SEL_FB_DIV = 6'h01;
   localparam logic [SEL_W-1:0] SEL_REF_DIV = 6'h02;
   localparam logic [SEL_W-1:0] SEL_A_DIV = 6'h03;
   localparam logic [SEL_W-1:0] SEL_PRESC = 6'h04;
   localparam logic [SEL_W-1:0] SEL_PFD_UP = 6'h05;
   localparam logic [SEL_W-1:0] SEL_PFD_DOWN = 6'h06;
   localparam logic [SEL_W-1:0] SEL_MON_GROUND = 6'h20;
   localparam logic [SEL_W-1:0] SEL_FIRST_REFERENCE_INPUT_CLK = 6'h21;
   localparam logic [SEL_W-1:0] SEL_SECOND_REFERENCE_INPUT_CLK = 6'h22;
   localparam logic [SEL_W-1:0] SEL_SEL_CLK = 6'h23;
   localparam logic [SEL_W-1:0] SEL_UNSEL_CLK = 6'h24;
   localparam logic [SEL_W-1:0] SEL_SEL_OK = 6'h25;
   localparam logic [SEL_W-1:0] SEL_UNSEL_OK = 6'h26;
   localparam logic [SEL_W-1:0] SEL_FIRST_REFERENCE_INPUT_FREQ = 6'h27;
   localparam logic [SEL_W-1:0] SEL_SECOND_REFERENCE_INPUT_FREQ = 6'h28;
   localparam logic [SEL_W-1:0] SEL_BOTH_FREQ = 6'h29;
   localparam logic [SEL_W-1:0] SEL_ALL_LOCK = 6'h2A;
   localparam logic [SEL_W-1:0] SEL_CLK_FREQ = 6'h2B;
   localparam logic [SEL_W-1:0] SEL_REF_ID = 6'h2C;
   localparam logic [SEL_W-1:0] SEL_DLD = 6'h2D;
   localparam logic [SEL_W-1:0] SEL_HOLDOVER = 6'h2E;
   localparam logic [SEL_W-1:0] SEL_LD_CMP = 6'h2F;
   localparam logic [SEL_W-1:0] SEL_SUPPLY = 6'h30;
   localparam logic [SEL_W-1:0] SEL_FIRST_REFERENCE_INPUT_CLK_B = 6'h31;
   localparam logic [SEL_W-1:0] SEL_SECOND_REFERENCE_INPUT_CLK_B = 6'h32;
   localparam logic [SEL_W-1:0] SEL_SEL_CLK_B = 6'h33;
   localparam logic [SEL_W-1:0] SEL_UNSEL_CLK_B = 6'h34;
   localparam logic [SEL_W-1:0] SEL_SEL_OK_N = 6'h35;
   localparam logic [SEL_W-1:0] SEL_UNSEL_OK_N = 6'h36;
   localparam logic [SEL_W-1:0] SEL_FIRST_REFERENCE_INPUT_FREQ_N = 6'h37;
   localparam logic [SEL_W-1:0] SEL_SECOND_REFERENCE_INPUT_FREQ_N = 6'h38;
   localparam logic [SEL_W-1:0] SEL_BOTH_FREQ_B = 6'h39;
   localparam logic [SEL_W-1:0] SEL_ALL_LOCK_B = 6'h3A;
   localparam logic [SEL_W-1:0] SEL_CLK_FREQ_N = 6'h3B;
   localparam logic [SEL_W-1:0] SEL_REF_ID_N = 6'h3C;
   localparam logic [SEL_W-1:0] SEL_DLD_N = 6'h3D;
   localparam logic [SEL_W-1:0] SEL_HOLDOVER_N = 6'h3E;
   localparam logic [SEL_W-1:0] SEL_LD_CMP_N = 6'h3F;

endpackage : sps_pkg

// ==== core/sps_prescaler.sv ====
/*
 * Feedback prescaler model: divides the clock by the modulus that the
 * prescaler code and the A counter state pick, one pulse per period.
 * Assumes a_nonzero is synchronous to clk.
 */
module sps_prescaler
   import sps_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [PRE_W-1:0] presc_code,
   input wire logic a_nonzero,
   output logic presc_out_q,
   output logic [CNT_W-1:0] modulus_q
);

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic presc_out_d;
   logic [CNT_W-1:0] modulus_d;

   // base P for dual modulus, fixed value otherwise
   function automatic logic [CNT_W-1:0] sps_modulus(input logic [PRE_W-1:0] code,
                                                    input logic a_nz);
      logic [CNT_W-1:0] base;
      logic dm;
      base = 6'h01;
      dm = 1'b1;
      unique case (code)
         PRE_FD_1: begin
            base = 6'h01;
            dm = 1'b0;
         end
         PRE_FD_2: begin
            base = 6'h02;
            dm = 1'b0;
         end
         PRE_DM_2: base = 6'h02;
         PRE_DM_4: base = 6'h04;
         PRE_DM_8: base = 6'h08;
         PRE_DM_16: base = 6'h10;
         PRE_DM_32: base = 6'h20;
         PRE_FD_3: begin
            base = 6'h03;
            dm = 1'b0;
         end
      endcase
      return base + {5'h00, dm & a_nz};
   endfunction : sps_modulus

   always_comb begin
      modulus_d = sps_modulus(presc_code, a_nonzero);
      if (count_q >= modulus_d - 6'h01) begin
         count_d = 6'h00;
         presc_out_d = 1'b1;
      end else begin
         count_d = count_q + 6'h01;
         presc_out_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_q <= 6'h00;
         presc_out_q <= 1'b0;
         modulus_q <= 6'h00;
      end else begin
         count_q <= count_d;
         presc_out_q <= presc_out_d;
         modulus_q <= modulus_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_dm_thirtythree: assert property (
      (presc_code == PRE_DM_32) && a_nonzero |=> modulus_q == 6'h21)
      else $error("prescaler code 110 with A nonzero is not divide by 33");
   chk_dm_low_modulus: assert property (
      (presc_code == PRE_DM_8) && !a_nonzero |=> modulus_q == 6'h08)
      else $error("dual modulus with A zero is not divide by P");
   chk_fd_every_cycle: assert property (
      (presc_code == PRE_FD_1) [*2] |=> presc_out_q)
      else $error("divide by one prescaler missed a pulse");

endmodule : sps_prescaler

// ==== core/sps_status_select.sv ====
/*
 * Status pin selector with the feedback prescaler, configuration held in
 * the pll control, status pin select and gate control registers.
 * Assumes all monitor inputs and the register port are synchronous to clk.
 */
module sps_status_select
   import sps_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata_q,
   input wire logic a_counter_nonzero,
   input wire logic fb_div_out,
   input wire logic ref_div_out,
   input wire logic a_div_out,
   input wire logic pfd_up,
   input wire logic pfd_down,
   input wire logic first_reference_input_clk,
   input wire logic second_reference_input_clk,
   input wire logic differential_mode,
   input wire logic ref_sel_second,
   input wire logic first_reference_input_status,
   input wire logic second_reference_input_status,
   input wire logic first_reference_input_freq_ok,
   input wire logic second_reference_input_freq_ok,
   input wire logic vco_status,
   input wire logic clk_freq_ok,
   input wire logic digital_lock_detect,
   input wire logic holdover_active,
   input wire logic lock_comparator,
   output logic prescaler_out_q,
   output logic status_pin_q
);

   logic [DATA_W-1:0] pll_ctrl_q;
   logic [DATA_W-1:0] pll_ctrl_d;
   logic [DATA_W-1:0] status_sel_q;
   logic [DATA_W-1:0] status_sel_d;
   logic [DATA_W-1:0] gate_ctrl_q;
   logic [DATA_W-1:0] gate_ctrl_d;
   logic [DATA_W-1:0] rdata_d;
   logic status_pin_d;
   logic [SEL_W-1:0] sel;
   logic sel_locked;
   logic presc_pulse;
   logic sel_clk;
   logic unsel_clk;
   logic second_reference_input_avail;
   logic sel_ok;
   logic unsel_ok;
   logic ref_id;
   logic all_lock;

   sps_prescaler u_prescaler (
      .clk(clk),
      .sys_rst(sys_rst),
      .presc_code(pll_ctrl_q[PRE_MSB:PRE_LSB]),
      .a_nonzero(a_counter_nonzero),
      .presc_out_q(presc_pulse),
      .modulus_q()
   );

   assign sel = status_sel_q[SEL_MSB:SEL_LSB];
   assign sel_locked = gate_ctrl_q[LOCK_BIT];

   // register writes and reads
   always_comb begin
      pll_ctrl_d = pll_ctrl_q;
      status_sel_d = status_sel_q;
      gate_ctrl_d = gate_ctrl_q;
      rdata_d = reg_rdata_q;
      if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_PLL_CTRL: pll_ctrl_d = reg_wdata;
            ADDR_STATUS_PIN_SELECT: begin
               // selection field frozen while gated; low bits always writable
               if (!sel_locked) begin
                  status_sel_d = reg_wdata;
               end else begin
                  status_sel_d = {status_sel_q[SEL_MSB:SEL_LSB], reg_wdata[SEL_LSB-1:0]};
               end
            end
            ADDR_GATE_CTRL: gate_ctrl_d = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd_en) begin
         unique case (reg_addr)
            ADDR_PLL_CTRL: rdata_d = pll_ctrl_q;
            ADDR_STATUS_PIN_SELECT: rdata_d = status_sel_q;
            ADDR_GATE_CTRL: rdata_d = gate_ctrl_q;
            default: rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   // reference routing; second and unselected references absent in differential mode
   always_comb begin
      second_reference_input_avail = differential_mode ? 1'b0 : second_reference_input_clk;
      if (differential_mode) begin
         sel_clk = first_reference_input_clk;
         unsel_clk = 1'b0;
         sel_ok = first_reference_input_status;
         unsel_ok = 1'b0;
         ref_id = 1'b0;
      end else begin
         sel_clk = ref_sel_second ? second_reference_input_clk : first_reference_input_clk;
         unsel_clk = ref_sel_second ? first_reference_input_clk : second_reference_input_clk;
         sel_ok = ref_sel_second ? second_reference_input_status : first_reference_input_status;
         unsel_ok = ref_sel_second ? first_reference_input_status : second_reference_input_status;
         ref_id = ref_sel_second;
      end
      all_lock = digital_lock_detect & sel_ok & vco_status;
   end

   // status pin selection
   always_comb begin
      unique case (sel)
         SEL_FB_DIV: status_pin_d = fb_div_out;
         SEL_REF_DIV: status_pin_d = ref_div_out;
         SEL_A_DIV: status_pin_d = a_div_out;
         SEL_PRESC: status_pin_d = presc_pulse;
         SEL_PFD_UP: status_pin_d = pfd_up;
         SEL_PFD_DOWN: status_pin_d = pfd_down;
         SEL_MON_GROUND: status_pin_d = 1'b0;
         SEL_FIRST_REFERENCE_INPUT_CLK: status_pin_d = first_reference_input_clk;
         SEL_SECOND_REFERENCE_INPUT_CLK: status_pin_d = second_reference_input_avail;
         SEL_SEL_CLK: status_pin_d = sel_clk;
         SEL_UNSEL_CLK: status_pin_d = unsel_clk;
         SEL_SEL_OK: status_pin_d = sel_ok;
         SEL_UNSEL_OK: status_pin_d = unsel_ok;
         SEL_FIRST_REFERENCE_INPUT_FREQ: status_pin_d = first_reference_input_freq_ok;
         SEL_SECOND_REFERENCE_INPUT_FREQ: status_pin_d = second_reference_input_freq_ok;
         SEL_BOTH_FREQ: status_pin_d = first_reference_input_freq_ok & second_reference_input_freq_ok;
         SEL_ALL_LOCK: status_pin_d = all_lock;
         SEL_CLK_FREQ: status_pin_d = clk_freq_ok;
         SEL_REF_ID: status_pin_d = ref_id;
         SEL_DLD: status_pin_d = digital_lock_detect;
         SEL_HOLDOVER: status_pin_d = holdover_active;
         SEL_LD_CMP: status_pin_d = lock_comparator;
         SEL_SUPPLY: status_pin_d = 1'b1;
         SEL_FIRST_REFERENCE_INPUT_CLK_B: status_pin_d = first_reference_input_clk;
         SEL_SECOND_REFERENCE_INPUT_CLK_B: status_pin_d = second_reference_input_avail;
         SEL_SEL_CLK_B: status_pin_d = sel_clk;
         SEL_UNSEL_CLK_B: status_pin_d = unsel_clk;
         SEL_SEL_OK_N: status_pin_d = ~sel_ok;
         SEL_UNSEL_OK_N: status_pin_d = differential_mode ? 1'b0 : ~unsel_ok;
         SEL_FIRST_REFERENCE_INPUT_FREQ_N: status_pin_d = ~first_reference_input_freq_ok;
         SEL_SECOND_REFERENCE_INPUT_FREQ_N: status_pin_d = ~second_reference_input_freq_ok;
         SEL_BOTH_FREQ_B: status_pin_d = first_reference_input_freq_ok & second_reference_input_freq_ok;
         SEL_ALL_LOCK_B: status_pin_d = all_lock;
         SEL_CLK_FREQ_N: status_pin_d = ~clk_freq_ok;
         SEL_REF_ID_N: status_pin_d = ~ref_id;
         SEL_DLD_N: status_pin_d = ~digital_lock_detect;
         SEL_HOLDOVER_N: status_pin_d = ~holdover_active;
         SEL_LD_CMP_N: status_pin_d = ~lock_comparator;
         default: status_pin_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_ctrl_q <= RST_PLL_CTRL;
         status_sel_q <= RST_STATUS_PIN_SELECT;
         gate_ctrl_q <= RST_GATE_CTRL;
         reg_rdata_q <= READ_UNMAPPED;
         status_pin_q <= 1'b0;
         prescaler_out_q <= 1'b0;
      end else begin
         pll_ctrl_q <= pll_ctrl_d;
         status_sel_q <= status_sel_d;
         gate_ctrl_q <= gate_ctrl_d;
         reg_rdata_q <= rdata_d;
         status_pin_q <= status_pin_d;
         prescaler_out_q <= presc_pulse;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_gated_write_ignored: assert property (
      reg_wr_en && reg_addr == ADDR_STATUS_PIN_SELECT && sel_locked |=> $stable(sel))
      else $error("selection changed while gated");
   chk_write_then_pin: assert property (
      reg_wr_en && reg_addr == ADDR_STATUS_PIN_SELECT && !sel_locked
      && reg_wdata[SEL_MSB:SEL_LSB] == SEL_SUPPLY |=> ##1 status_pin_q)
      else $error("new selection not on pin two cycles after write");
   chk_ground_undefined: assert property (
      !sel[SEL_W-1] && sel > SEL_PFD_DOWN |=> !status_pin_q)
      else $error("undefined low code not ground");
   chk_pfd_up_pass: assert property (
      sel == SEL_PFD_UP |=> status_pin_q == $past(pfd_up))
      else $error("up pulse not passed to pin");
   chk_diff_second_reference_input_absent: assert property (
      sel == SEL_SECOND_REFERENCE_INPUT_CLK && differential_mode |=> !status_pin_q)
      else $error("second reference shown in differential mode");
   chk_both_freq_and: assert property (
      sel == SEL_BOTH_FREQ |=> status_pin_q == $past(first_reference_input_freq_ok & second_reference_input_freq_ok))
      else $error("frequency AND wrong");
   chk_lock_combo: assert property (
      sel == SEL_ALL_LOCK && !vco_status |=> !status_pin_q)
      else $error("lock combination high without VCO status");
   chk_ref_identity: assert property (
      sel == SEL_REF_ID && !differential_mode |=> status_pin_q == $past(ref_sel_second))
      else $error("reference identity wrong");
   chk_supply_high: assert property (
      sel == SEL_SUPPLY [*2] |=> status_pin_q)
      else $error("supply code not high");
   chk_holdover_low: assert property (
      sel == SEL_HOLDOVER_N |=> status_pin_q != $past(holdover_active))
      else $error("inverted holdover not inverted");
   chk_level_follows: assert property (
      sel == SEL_DLD && $rose(digital_lock_detect) |=> status_pin_q)
      else $error("level selection does not follow flag");
   chk_ungated_write_taken: assert property (
      reg_wr_en && reg_addr == ADDR_STATUS_PIN_SELECT && !sel_locked
      |=> sel == $past(reg_wdata[SEL_MSB:SEL_LSB]))
      else $error("selection write lost while not gated");
   chk_low_bits_written: assert property (
      reg_wr_en && reg_addr == ADDR_STATUS_PIN_SELECT
      |=> status_sel_q[SEL_LSB-1:0] == $past(reg_wdata[SEL_LSB-1:0]))
      else $error("low bits of selection register not written");
   chk_fb_div_pass: assert property (
      sel == SEL_FB_DIV |=> status_pin_q == $past(fb_div_out))
      else $error("feedback divider output not passed to pin");
   chk_presc_pass: assert property (
      sel == SEL_PRESC |=> status_pin_q == $past(presc_pulse))
      else $error("prescaler output not passed to pin");
   chk_first_reference_input_clk_pass: assert property (
      sel == SEL_FIRST_REFERENCE_INPUT_CLK |=> status_pin_q == $past(first_reference_input_clk))
      else $error("first reference clock not passed to pin");
   chk_diff_unsel_absent: assert property (
      sel == SEL_UNSEL_CLK && differential_mode |=> !status_pin_q)
      else $error("unselected reference shown in differential mode");
   chk_ref_id_low: assert property (
      sel == SEL_REF_ID_N && !differential_mode |=> status_pin_q == !$past(ref_sel_second))
      else $error("inverted reference identity wrong");
   chk_dld_low: assert property (
      sel == SEL_DLD_N |=> status_pin_q != $past(digital_lock_detect))
      else $error("inverted lock detect not inverted");

endmodule : sps_status_select

// ==== verification/sps_status_select_tb.sv ====
/*
 * Self-checking bench for the status pin selector and feedback prescaler:
 * register access, lock of the selection field, every selection code
 * except the prescaler code 04 under several monitor patterns, pin latency and prescaler moduli.
 * Assumes the sps_pkg package and the sps_status_select top module.
 */
module sps_status_select_tb
   import sps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 10'h000;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic [DATA_W-1:0] reg_rdata_q;
   logic a_counter_nonzero = 1'b1;
   logic [17:0] mon = 18'h00000;
   logic fb_div_out, ref_div_out, a_div_out, pfd_up, pfd_down, first_reference_input_clk, second_reference_input_clk;
   logic differential_mode, ref_sel_second, first_reference_input_status, second_reference_input_status, first_reference_input_freq_ok;
   logic second_reference_input_freq_ok, vco_status, clk_freq_ok, digital_lock_detect, holdover_active;
   logic lock_comparator, prescaler_out_q, status_pin_q;
   int miscompares = 0;
   int checked = 0;
   logic [17:0] pats [4] = '{18'h2A1A5, 18'h15A5A, 18'h3FBFF, 18'h0079C};
   logic [7:0] rv;
   logic [7:0] per;
   logic [7:0] exp_per;

   assign {fb_div_out, ref_div_out, a_div_out, pfd_up, pfd_down, first_reference_input_clk, second_reference_input_clk,
      differential_mode, ref_sel_second, first_reference_input_status, second_reference_input_status, first_reference_input_freq_ok,
      second_reference_input_freq_ok, vco_status, clk_freq_ok, digital_lock_detect, holdover_active,
      lock_comparator} = mon;

   always #4 clk = ~clk;

   sps_status_select DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .a_counter_nonzero(a_counter_nonzero),
      .fb_div_out(fb_div_out), .ref_div_out(ref_div_out), .a_div_out(a_div_out),
      .pfd_up(pfd_up), .pfd_down(pfd_down), .first_reference_input_clk(first_reference_input_clk), .second_reference_input_clk(second_reference_input_clk),
      .differential_mode(differential_mode), .ref_sel_second(ref_sel_second),
      .first_reference_input_status(first_reference_input_status), .second_reference_input_status(second_reference_input_status), .first_reference_input_freq_ok(first_reference_input_freq_ok),
      .second_reference_input_freq_ok(second_reference_input_freq_ok), .vco_status(vco_status), .clk_freq_ok(clk_freq_ok),
      .digital_lock_detect(digital_lock_detect), .holdover_active(holdover_active),
      .lock_comparator(lock_comparator), .prescaler_out_q(prescaler_out_q),
      .status_pin_q(status_pin_q));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      #1 reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      #1 reg_rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_rd_en = 1'b0;
      @(posedge clk);
      #1 d = reg_rdata_q;
   endtask : rd

   // write a selection and let it reach the pin
   task automatic sel(input logic [5:0] c);
      wr(ADDR_STATUS_PIN_SELECT, {c, 2'b00});
      repeat (3) @(posedge clk);
      #1;
   endtask : sel

   function automatic logic pin_base(input logic [5:0] c);
      logic dm;
      logic s_clk;
      logic u_clk;
      logic s_st;
      logic u_st;
      dm = differential_mode;
      s_clk = (dm || !ref_sel_second) ? first_reference_input_clk : second_reference_input_clk;
      u_clk = dm ? 1'b0 : (ref_sel_second ? first_reference_input_clk : second_reference_input_clk);
      s_st = (dm || !ref_sel_second) ? first_reference_input_status : second_reference_input_status;
      u_st = dm ? 1'b0 : (ref_sel_second ? first_reference_input_status : second_reference_input_status);
      case (c)
         6'h01: return fb_div_out;
         6'h02: return ref_div_out;
         6'h03: return a_div_out;
         6'h05: return pfd_up;
         6'h06: return pfd_down;
         6'h21: return first_reference_input_clk;
         6'h22: return dm ? 1'b0 : second_reference_input_clk;
         6'h23: return s_clk;
         6'h24: return u_clk;
         6'h25: return s_st;
         6'h26: return u_st;
         6'h27: return first_reference_input_freq_ok;
         6'h28: return second_reference_input_freq_ok;
         6'h29: return first_reference_input_freq_ok & second_reference_input_freq_ok;
         6'h2A: return digital_lock_detect & s_st & vco_status;
         6'h2B: return clk_freq_ok;
         6'h2C: return !dm && ref_sel_second;
         6'h2D: return digital_lock_detect;
         6'h2E: return holdover_active;
         6'h2F: return lock_comparator;
         6'h30: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : pin_base

   function automatic logic pin_exp(input logic [5:0] c);
      logic v;
      v = pin_base((c > 6'h30) ? c - 6'h10 : c);
      if (c >= 6'h35 && c != 6'h39 && c != 6'h3A && !(c == 6'h36 && differential_mode)) begin
         v = ~v;
      end
      return v;
   endfunction : pin_exp

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // cycles between two prescaler pulses, bounded
   task automatic period(output logic [7:0] p);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (prescaler_out_q !== 1'b1 && n < 100);
      end
      p = n[7:0];
   endtask : period

   initial begin
      #400000;
      miscompares++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      rd(ADDR_PLL_CTRL, rv);
      check("prescaler reset", rv, RST_PLL_CTRL);
      rd(ADDR_STATUS_PIN_SELECT, rv);
      check("select reset", rv, RST_STATUS_PIN_SELECT);
      rd(ADDR_GATE_CTRL, rv);
      check("gate reset", rv, RST_GATE_CTRL);
      check("pin after reset", {7'h00, status_pin_q}, 8'h00);
      wr(10'h100, 8'hFF);
      rd(10'h100, rv);
      check("unmapped read", rv, READ_UNMAPPED);
      $display("test reset done");

      mon = 18'h04000;
      sel(SEL_SUPPLY);
      check("supply level", {7'h00, status_pin_q}, 8'h01);
      wr(ADDR_GATE_CTRL, 8'h80);
      wr(ADDR_STATUS_PIN_SELECT, 8'h17);
      rd(ADDR_STATUS_PIN_SELECT, rv);
      check("locked select", rv, 8'hC3);
      check("pin while locked", {7'h00, status_pin_q}, 8'h01);
      wr(ADDR_GATE_CTRL, 8'h00);
      wr(ADDR_STATUS_PIN_SELECT, 8'h17);
      rd(ADDR_STATUS_PIN_SELECT, rv);
      check("unlocked select", rv, 8'h17);
      check("pin after unlock", {7'h00, status_pin_q}, 8'h01);
      $display("test lock done");

      for (int i = 0; i < 8; i++) begin
         mon[14] = i[0] ^ i[2];
         @(posedge clk);
         #1 check("pin follows up pulse", {7'h00, status_pin_q}, {7'h00, i[0] ^ i[2]});
      end
      $display("test toggling done");

      foreach (pats[p]) begin
         mon = pats[p];
         for (int c = 0; c < 64; c++) begin
            if (c != 4) begin
               sel(c[5:0]);
               check($sformatf("pin code %h", c), {7'h00, status_pin_q},
                  {7'h00, pin_exp(c[5:0])});
            end
         end
      end
      $display("test selection table done");

      for (int k = 0; k < 16; k++) begin
         a_counter_nonzero = k[0];
         if (k > 1) begin
            wr(ADDR_PLL_CTRL, {5'h00, k[3:1]});
         end else begin
            wr(ADDR_PLL_CTRL, {5'h00, PRE_DM_32});
         end
         case (k[3:1])
            3'h0: exp_per = (k > 1) ? 8'h01 : 8'h20 + {7'h00, k[0]};
            3'h1: exp_per = 8'h02;
            3'h7: exp_per = 8'h03;
            default: exp_per = (8'h01 << (k[3:1] - 3'h1)) + {7'h00, k[0]};
         endcase
         period(per);
         check($sformatf("prescaler period %0d", k), per, exp_per);
      end
      wr(ADDR_PLL_CTRL, {5'h00, PRE_FD_1});
      period(per);
      check("prescaler divide by one", per, 8'h01);
      $display("test prescaler done");
      test_done();
   end
endmodule : sps_status_select_tb
